// >>> design/pbcd_cfg.svh
/*
  Offsets, field positions, reset values for the port B change detector.
  Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
*/
`ifndef PBCD_CFG_SVH
`define PBCD_CFG_SVH
`define PBCD_OFS_RISE    6'h00
`define PBCD_OFS_FALL    6'h04
`define PBCD_OFS_FLAGS   6'h08
`define PBCD_OFS_CTRL    6'h0c
`define PBCD_OFS_MASK    6'h10
`define PBCD_PIN_LO      4
`define PBCD_CTRL_IE_BIT 3
`define PBCD_CTRL_SUM_BIT 0
`define PBCD_RST_NIB     4'h0
`define PBCD_RST_MASK    4'hf
`endif

// >>> design/pbcd_pkg.sv
/*
  Types for the port B change detector.
  Assumes pbcd_cfg.svh for numeric constants.
*/
`default_nettype none
package pbcd_pkg;
  typedef struct packed {
    logic [5:0]  adr;
    logic        we;
    logic        sel0;
    logic [7:0]  dat;
  } pbcd_req_type;
  typedef struct packed {
    logic [3:0] rise;
    logic [3:0] fall;
  } pbcd_edge_type;
endpackage : pbcd_pkg
`default_nettype wire

// >>> design/pbcd_top.sv
/*
  Port B pin-change detector with Wishbone classic register slave.
  Assumes pins synchronous-domain unknown, one clock, synchronous reset.
*/
`include "pbcd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pbcd_top
  import pbcd_pkg::*;
#(
  parameter int NPINS = 4
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [3:0]  port_b_pin_i,
  output var  logic        irq_o
);

  initial
  begin
    if (NPINS != 4)
      $error("pbcd_top serves exactly four pins");
  end

  function automatic logic [7:0] hi_nib(input logic [3:0] v);
    hi_nib = {v, 4'h0};
  endfunction : hi_nib

  pbcd_req_type  req;
  pbcd_edge_type ev;
  logic [3:0]  sync1_reg, sync2_reg, prev_reg;
  logic [3:0]  rise_reg, rise_next;
  logic [3:0]  fall_reg, fall_next;
  logic [3:0]  flags_reg, flags_next;
  logic [3:0]  mask_reg, mask_next;
  logic        ie_reg, ie_next;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic        irq_reg, irq_next;
  logic        access;
  logic        wr;
  logic [3:0]  hit;
  logic [3:0]  wnib;

  assign req.adr  = wb_adr_i[5:0];
  assign req.we   = wb_we_i;
  assign req.sel0 = wb_sel_i[0];
  assign req.dat  = wb_dat_i[7:0];
  assign access   = wb_cyc_i & wb_stb_i;
  // Writes commit on the edge that the master samples ack
  assign wr       = access & req.we & req.sel0 & ack_reg & (wb_adr_i[31:6] == 26'h0);
  assign wnib     = req.dat[7:4]; // Low nibble dropped on write

  // Edge detect after the second synchroniser stage only
  always_comb
  begin
    ev.rise = sync2_reg & ~prev_reg & rise_reg;
    ev.fall = ~sync2_reg & prev_reg & fall_reg;
    hit     = ev.rise | ev.fall;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end
    else
    begin
      sync1_reg <= port_b_pin_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always_comb
  begin
    rise_next  = rise_reg;
    fall_next  = fall_reg;
    flags_next = flags_reg;
    mask_next  = mask_reg;
    ie_next    = ie_reg;
    if (wr)
    begin
      case (req.adr)
        `PBCD_OFS_RISE:  rise_next  = wnib;
        `PBCD_OFS_FALL:  fall_next  = wnib;
        `PBCD_OFS_FLAGS: flags_next = wnib;
        `PBCD_OFS_CTRL:  ie_next    = req.dat[`PBCD_CTRL_IE_BIT];
        `PBCD_OFS_MASK:  mask_next  = wnib;
        default:         ie_next    = ie_reg;
      endcase
    end
    // Set wins over a clearing write in the same cycle
    flags_next = flags_next | hit;
    irq_next   = ie_reg & (|(flags_reg & mask_reg));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rise_reg  <= `PBCD_RST_NIB;
      fall_reg  <= `PBCD_RST_NIB;
      flags_reg <= `PBCD_RST_NIB;
      mask_reg  <= `PBCD_RST_MASK;
      ie_reg    <= 1'b0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      rise_reg  <= rise_next;
      fall_reg  <= fall_next;
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
      ie_reg    <= ie_next;
      irq_reg   <= irq_next;
    end
  end

  // Bus answer: ack one cycle after the request, read data latched with it
  always_comb
  begin
    ack_next = access & ~ack_reg;
    dat_next = dat_reg;
    if (access & ~ack_reg)
    begin
      dat_next = 32'h0;
      if (wb_adr_i[31:6] == 26'h0)
      begin
        case (req.adr)
          `PBCD_OFS_RISE:  dat_next[7:0] = hi_nib(rise_reg);
          `PBCD_OFS_FALL:  dat_next[7:0] = hi_nib(fall_reg);
          `PBCD_OFS_FLAGS: dat_next[7:0] = hi_nib(flags_reg);
          `PBCD_OFS_MASK:  dat_next[7:0] = hi_nib(mask_reg);
          `PBCD_OFS_CTRL:
          begin
            dat_next[`PBCD_CTRL_IE_BIT]  = ie_reg;
            dat_next[`PBCD_CTRL_SUM_BIT] = |flags_reg;
          end
          default: dat_next = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = irq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_rise_sets_flag: assert property (
    (|ev.rise) |=> ((flags_reg & $past(ev.rise)) == $past(ev.rise)))
    else $error("rising edge did not set its flag");

  chk_fall_sets_flag: assert property (
    (|ev.fall) |=> ((flags_reg & $past(ev.fall)) == $past(ev.fall)))
    else $error("falling edge did not set its flag");

  chk_flag_cause: assert property (
    !$past(wr) |-> ((flags_reg & ~$past(flags_reg) & ~$past(hit)) == 4'h0))
    else $error("flag set without enabled edge");

  chk_clear_holds: assert property (
    (wr && req.adr == `PBCD_OFS_FLAGS && hit == 4'h0) |=> (flags_reg == $past(wnib)))
    else $error("flag write not applied");

  chk_set_wins: assert property (
    (wr && req.adr == `PBCD_OFS_FLAGS) |=> ((flags_reg & $past(hit)) == $past(hit)))
    else $error("edge lost during clearing write");

  chk_low_nib_zero: assert property (
    ($rose(wb_ack_o) && $past(req.adr) != `PBCD_OFS_CTRL) |-> (wb_dat_o[3:0] == 4'h0))
    else $error("unimplemented bits read nonzero");

  chk_reset_zero: assert property (
    $past(rst_i) |-> (rise_reg == 4'h0 && fall_reg == 4'h0 && flags_reg == 4'h0))
    else $error("enable or flag not zero after reset");

  chk_irq_gated: assert property (
    !ie_reg |=> !irq_o)
    else $error("interrupt raised while disabled");

  chk_irq_raised: assert property (
    (ie_reg && |(flags_reg & mask_reg)) |=> irq_o)
    else $error("interrupt missing");

  chk_sync_depth: assert property (
    (|ev.rise) |-> (($past(port_b_pin_i, 2) & ev.rise) == ev.rise))
    else $error("edge seen before two sync stages");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  cov_rise_flag: cover property ((|ev.rise) ##1 (|flags_reg));
  cov_fall_flag: cover property ((|ev.fall) ##1 (|flags_reg));
  cov_set_wins: cover property (wr && req.adr == `PBCD_OFS_FLAGS && (|hit));
  cov_irq: cover property (!irq_o ##1 irq_o);

endmodule : pbcd_top
`default_nettype wire

// >>> bench/pbcd_pin_model.sv
/*
  External driver of the four upper port B pins.
  Assumes the bench hands it the wanted levels on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pbcd_pin_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,
  output var  logic [3:0] pin_o
);
  // Pins move just after an edge, as a slow outside source would
  always_ff @(posedge clk_i)
  begin
    pin_o <= level_i;
  end
endmodule : pbcd_pin_model
`default_nettype wire

// >>> bench/test_port_b_pin_change_detect.sv
/*
  Self-checking bench for the port B change detector.
  Assumes pbcd_top, the pin model and pbcd_cfg.svh offsets.
*/
`include "pbcd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_port_b_pin_change_detect;
  logic        clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  lvl, pins, rise_en, fall_en, expf, old, msk;
  logic [15:0] seed;
  logic [7:0]  q;
  int          fails, cmp_count;
  pbcd_pin_model u_pins (.clk_i(clk_i), .level_i(lvl), .pin_o(pins));
  pbcd_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_b_pin_i(pins), .irq_o(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Classic single cycle; waits for ack under a bounded count
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {26'h0, a}; wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk("ack", 8'h01, 8'h00);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  task automatic reset_chk();
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `PBCD_OFS_RISE, 0);  chk("rise", 8'h00, q);
    wb(0, `PBCD_OFS_FALL, 0);  chk("fall", 8'h00, q);
    wb(0, `PBCD_OFS_FLAGS, 0); chk("flags", 8'h00, q);
    wb(0, `PBCD_OFS_MASK, 0);  chk("mask", 8'hf0, q);
    wb(0, 6'h20, 0);           chk("unmapped", 8'h00, q);
    expf = 4'h0; msk = 4'hf;
  endtask : reset_chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
  initial
  begin
    rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; lvl = 0;
    fails = 0; cmp_count = 0; seed = 16'hb393; old = 0;
    for (int r = 0; r < 2; r++)
    begin
      reset_chk();
      wb(1, `PBCD_OFS_RISE, 8'hff);  wb(0, `PBCD_OFS_RISE, 0);  chk("rise", 8'hf0, q);
      wb(1, `PBCD_OFS_FLAGS, 8'h0f); wb(0, `PBCD_OFS_FLAGS, 0); chk("flags", 8'h00, q);
      wb(1, `PBCD_OFS_CTRL, {4'h0, r[0] ? 1'b0 : 1'b1, 3'h0});
      for (int i = 0; i < 40; i++)
      begin
        seed = lfsr(seed); rise_en = seed[3:0]; fall_en = seed[7:4];
        wb(1, `PBCD_OFS_RISE, {rise_en, 4'h0});
        wb(1, `PBCD_OFS_FALL, {fall_en, 4'h0});
        seed = lfsr(seed);
        @(posedge clk_i);
        lvl <= seed[3:0];
        repeat (6) @(posedge clk_i);
        expf = expf | (~old & seed[3:0] & rise_en) | (old & ~seed[3:0] & fall_en);
        old = seed[3:0];
        wb(0, `PBCD_OFS_FLAGS, 0); chk("flags", {expf, 4'h0}, q);
        wb(0, `PBCD_OFS_CTRL, 0);  chk("summary", {7'h0, |expf}, {7'h0, q[0]});
        msk = seed[15:12];
        wb(1, `PBCD_OFS_MASK, {msk, 4'h0});
        repeat (2) @(posedge clk_i);
        chk("irq", {7'h0, ~r[0] & |(expf & msk)}, {7'h0, irq});
        expf = expf & seed[11:8];
        wb(1, `PBCD_OFS_FLAGS, {expf, 4'h0});
        wb(0, `PBCD_OFS_FLAGS, 0); chk("cleared", {expf, 4'h0}, q);
      end
    end
    end_of_test();
  end
endmodule : test_port_b_pin_change_detect
`default_nettype wire
